// [cdfs_host_model.sv]
`timescale 1ns/1ps
module cdfs_host_model #(
    parameter int HoldOff = 3000
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic wantSession,
    input wire logic eventN,
    output logic sessionRequestN = 1'b1,
    output logic resetIn = 1'b0
);
    int waitCount;
    // host raises card reset one cycle after it pulls its session request low
    always_ff @(posedge clock) begin
        resetIn <= !sessionRequestN;
        if (srst) begin
            sessionRequestN <= 1'b1;
            waitCount <= 0;
        end else if (!sessionRequestN) begin
            if (!wantSession || !eventN) begin
                sessionRequestN <= 1'b1;
                waitCount <= HoldOff;
            end
        end else if (waitCount > 0) begin
            waitCount <= waitCount - 1;
        end else if (wantSession && eventN) begin
            sessionRequestN <= 1'b0;
        end
    end
endmodule

// [cdfs_monitor.sv]
`timescale 1ns/1ps
module cdfs_monitor
    import cdfs_pkg::*;
#(
    parameter int DebounceCycles = cdfs_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic sessionRequestN,
    input wire logic eventN,
    input wire logic cardDetect,
    input wire logic hostSupplyLow,
    input wire logic cardSupplyFault,
    input wire logic cardSupplyRangeFault,
    input wire logic regulatorInputLow,
    input wire logic overTemp,
    input wire logic cardResetOut,
    input wire logic cardClockOut,
    input wire logic cardDataLowOut,
    input wire logic cardAuxALowOut,
    input wire logic cardAuxBLowOut,
    input wire logic cardSupplyOut
);
    import cdfs_pkg::*;
    int rstLowCount;
    int cardCount;
    int reqLowCount;
    int removalCount;
    int faultOnCount;
    wire anyFault = hostSupplyLow | cardSupplyFault | cardSupplyRangeFault;
    wire anyFaultAll = anyFault | regulatorInputLow | overTemp;
    wire linesLow = cardDataLowOut & cardAuxALowOut & cardAuxBLowOut;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // run lengths, cleared in reset so time spent in reset never counts
    always_ff @(posedge clock) begin
        rstLowCount <= (srst || !cardClockOut || cardResetOut) ? 0 : rstLowCount + 1;
        cardCount <= (srst || !cardDetect) ? 0 : cardCount + 1;
        reqLowCount <= (srst || sessionRequestN) ? 0 : reqLowCount + 1;
    end
    // supply-on time under removal or fault; a full deactivation must end each run
    always_ff @(posedge clock) begin
        removalCount <= (srst || !cardSupplyOut || cardDetect) ? 0 : removalCount + 1;
        faultOnCount <= (srst || !cardSupplyOut || !anyFaultAll) ? 0 : faultOnCount + 1;
    end
    a_clock_after_reset: assert property ($fell(cardClockOut) |-> rstLowCount >= CLK_LOW_CYCLES - 1)
        else $error("card clock stopped too soon");
    a_lines_after_clock: assert property ($rose(linesLow) |-> !cardClockOut)
        else $error("lines pulled low with clock running");
    a_supply_last: assert property ($fell(cardSupplyOut) |-> $past(linesLow) && !$past(cardClockOut))
        else $error("supply off before lines low");
    a_removal_event: assert property ((!cardDetect)[*5] |-> !eventN)
        else $error("event high without card");
    a_removal_ends_session: assert property (removalCount <= 2414)
        else $error("removal did not end session");
    a_debounce_wait: assert property ($rose(eventN) |-> cardCount >= DebounceCycles)
        else $error("event rose before debounce");
    a_host_low_event: assert property (hostSupplyLow[*5] |-> !eventN)
        else $error("event high in undervoltage");
    a_fault_event: assert property ((cardSupplyOut && anyFaultAll)[*5] |-> !eventN)
        else $error("fault not reported");
    a_fault_deact: assert property (faultOnCount <= 2413)
        else $error("fault did not deactivate");
    a_fresh_request: assert property ($rose(cardSupplyOut) |-> reqLowCount inside {[2:8]})
        else $error("session started without fresh request");
endmodule

bind cdfs_sequencer cdfs_monitor #(.DebounceCycles(DebounceCycles)) monitorInst (.*);

// [cdfs_sequencer.sv]
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module cdfs_sequencer
    import cdfs_pkg::*;
#(
    parameter int DebounceCycles = cdfs_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clock,
    input wire logic srst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // host side pins
    input wire logic sessionRequestN,
    input wire logic resetIn,
    output logic eventN,
    // card presence and fault comparators
    input wire logic cardDetect,
    input wire logic hostSupplyLow,
    input wire logic cardSupplyFault,
    input wire logic cardSupplyRangeFault,
    input wire logic regulatorInputLow,
    input wire logic overTemp,
    // card contact control
    output logic cardResetOut,
    output logic cardClockOut,
    output logic cardDataLowOut,
    output logic cardAuxALowOut,
    output logic cardAuxBLowOut,
    output logic cardSupplyOut
);
    import cdfs_pkg::*;

    cdfs_state_type state, next_state;
    logic [7:0] syncMeta;
    logic [7:0] syncOut;
    logic reqPrev;
    logic cardPrev;
    logic cardDebounced;
    logic faultLock;
    logic faultEvent;
    logic [FAULT_COUNT-1:0] faultLog;
    logic wrPending;
    logic [7:0] wrAddr;

    wire logic reqHigh;
    wire logic reqFall;
    wire logic resetInSync;
    wire logic cardSync;
    wire logic [FAULT_COUNT-1:0] faultVec;
    wire logic anyFault;
    wire logic inSession;
    wire logic abortReq;
    wire logic deactStart;
    wire logic clkTimerExpired;
    wire logic debStart;
    wire logic debExpired;
    wire logic next_faultLock;
    wire logic next_faultEvent;
    wire logic next_cardDebounced;
    wire logic [FAULT_COUNT-1:0] faultClear;
    wire logic [FAULT_COUNT-1:0] next_faultLog;
    wire logic addrPhase;
    wire logic [31:0] statusWord;
    wire logic [31:0] readMux;

    // every pin input passes two flops before any logic sees it
    always_ff @(posedge clock) begin
        if (srst) begin
            syncMeta <= SYNC_RESET;
            syncOut <= SYNC_RESET;
        end else begin
            syncMeta <= {sessionRequestN, resetIn, cardDetect, hostSupplyLow,
                         cardSupplyFault, cardSupplyRangeFault, regulatorInputLow, overTemp};
            syncOut <= syncMeta;
        end
    end

    // synchronised pin views
    assign reqHigh = syncOut[7];
    assign resetInSync = syncOut[6];
    assign cardSync = syncOut[5];
    assign reqFall = reqPrev && !reqHigh;
    assign debStart = cardSync && !cardPrev;

    // fault set; contact current limiting has no input and never reaches this logic
    assign faultVec[FLT_EXTRACT_BIT] = !cardSync;
    assign faultVec[FLT_HOST_LOW_BIT] = syncOut[4];
    assign faultVec[FLT_SUPPLY_SHORT_BIT] = syncOut[3];
    assign faultVec[FLT_SUPPLY_RANGE_BIT] = syncOut[2];
    assign faultVec[FLT_REG_LOW_BIT] = syncOut[1];
    assign faultVec[FLT_OVERTEMP_BIT] = syncOut[0];
    assign anyFault = |faultVec;
    assign inSession = (state != ST_IDLE);

    // edge history for request and card detect
    always_ff @(posedge clock) begin
        if (srst) begin
            reqPrev <= 1'b1;
            cardPrev <= 1'b0;
        end else begin
            reqPrev <= reqHigh;
            cardPrev <= cardSync;
        end
    end

    // insertion debounce timer; restarted on each rising detect so bounce restarts it
    cdfs_timer #(
        .W(TIMER_WIDTH)
    ) u_debounce (
        .clock(clock),
        .srst(srst),
        .start(debStart),
        .loadValue(TIMER_WIDTH'(DebounceCycles)),
        .expired(debExpired)
    );

    // removal clears at once, insertion only counts after the full interval
    assign next_cardDebounced = cardSync && (cardDebounced || debExpired);

    // deactivation delay between reset low and clock low
    cdfs_timer #(
        .W(TIMER_WIDTH)
    ) u_clk_delay (
        .clock(clock),
        .srst(srst),
        .start(deactStart),
        .loadValue(TIMER_WIDTH'(CLK_LOW_CYCLES)),
        .expired(clkTimerExpired)
    );

    // sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                // a held-low request after a fault gives no edge, so no restart
                if (reqFall && !faultLock && cardDebounced && !anyFault) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (reqHigh || anyFault || abortReq) begin
                    next_state = ST_DEACT_RST;
                end
            end
            ST_DEACT_RST: begin
                if (clkTimerExpired) begin
                    next_state = ST_DEACT_IO;
                end
            end
            ST_DEACT_IO: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    assign deactStart = (state == ST_ACTIVE) && (next_state == ST_DEACT_RST);

    always_ff @(posedge clock) begin
        if (srst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // contact outputs decoded from the next state so every pin is a flop
    always_ff @(posedge clock) begin
        if (srst) begin
            cardResetOut <= 1'b0;
            cardClockOut <= 1'b0;
            cardDataLowOut <= 1'b1;
            cardAuxALowOut <= 1'b1;
            cardAuxBLowOut <= 1'b1;
            cardSupplyOut <= 1'b0;
        end else begin
            cardResetOut <= (next_state == ST_ACTIVE) && resetInSync;
            cardClockOut <= (next_state == ST_ACTIVE) || (next_state == ST_DEACT_RST);
            cardDataLowOut <= (next_state == ST_IDLE) || (next_state == ST_DEACT_IO);
            cardAuxALowOut <= (next_state == ST_IDLE) || (next_state == ST_DEACT_IO);
            cardAuxBLowOut <= (next_state == ST_IDLE) || (next_state == ST_DEACT_IO);
            cardSupplyOut <= (next_state != ST_IDLE);
        end
    end

    // lock and fault event: set wins over the clear in the same cycle
    assign next_faultLock = (faultLock && !(reqHigh && !inSession))
                            || (inSession && (anyFault || abortReq));
    assign next_faultEvent = (faultEvent && !(reqHigh && !inSession))
                             || (inSession && anyFault);

    always_ff @(posedge clock) begin
        if (srst) begin
            faultLock <= 1'b0;
            faultEvent <= 1'b0;
            cardDebounced <= 1'b0;
        end else begin
            faultLock <= next_faultLock;
            faultEvent <= next_faultEvent;
            cardDebounced <= next_cardDebounced;
        end
    end

    // event line: card present, host supply good, no session fault pending
    always_ff @(posedge clock) begin
        if (srst) begin
            eventN <= 1'b0;
        end else begin
            eventN <= next_cardDebounced && !faultVec[FLT_HOST_LOW_BIT]
                      && !next_faultEvent;
        end
    end

    // ahb-lite slave: zero wait states, always okay
    assign addrPhase = hsel && htrans[1] && hready;
    assign abortReq = wrPending && (wrAddr == REG_CONTROL) && hwdata[CTRL_ABORT_BIT];
    assign faultClear = (wrPending && (wrAddr == REG_FAULT_LOG))
                        ? hwdata[FAULT_COUNT-1:0] : FAULT_LOG_RESET;
    // sticky log, write one to clear; a new fault beats its clear
    assign next_faultLog = (faultLog & ~faultClear) | faultVec;

    assign statusWord = {27'h0000000,
                         (state == ST_DEACT_RST) || (state == ST_DEACT_IO),
                         state == ST_ACTIVE,
                         faultLock,
                         eventN,
                         cardDebounced};
    // unmapped offsets read as zero
    assign readMux = (haddr[7:0] == REG_STATUS) ? statusWord :
                     (haddr[7:0] == REG_FAULT_LOG) ? {26'h0000000, faultLog} :
                     32'h00000000;

    always_ff @(posedge clock) begin
        if (srst) begin
            faultLog <= FAULT_LOG_RESET;
        end else begin
            faultLog <= next_faultLog;
        end
    end

    // address phase captured; read data ready for the data phase
    always_ff @(posedge clock) begin
        if (srst) begin
            wrPending <= 1'b0;
            wrAddr <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wrPending <= addrPhase && hwrite;
            wrAddr <= haddr[7:0];
            hrdata <= (addrPhase && !hwrite) ? readMux : 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule

// [cdfs_timer.sv]
package cdfs_pkg;
    // timing base
    localparam int CLOCK_MHZ = 200;
    localparam int CLK_LOW_DELAY_NS = 12000;
    // least time: round up to whole cycles
    localparam int CLK_LOW_CYCLES = (CLK_LOW_DELAY_NS * CLOCK_MHZ + 999) / 1000;
    localparam int DEBOUNCE_TIME_US = 8000;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_US * CLOCK_MHZ;
    localparam int TIMER_WIDTH = 21;

    // register byte offsets (low address byte decoded)
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_FAULT_LOG = 8'h08;

    // control fields
    localparam int CTRL_ABORT_BIT = 0;

    // status fields
    localparam int STAT_CARD_BIT = 0;
    localparam int STAT_EVENT_BIT = 1;
    localparam int STAT_LOCK_BIT = 2;
    localparam int STAT_SESSION_BIT = 3;
    localparam int STAT_DEACT_BIT = 4;

    // fault vector fields
    localparam int FLT_EXTRACT_BIT = 0;
    localparam int FLT_HOST_LOW_BIT = 1;
    localparam int FLT_SUPPLY_SHORT_BIT = 2;
    localparam int FLT_SUPPLY_RANGE_BIT = 3;
    localparam int FLT_REG_LOW_BIT = 4;
    localparam int FLT_OVERTEMP_BIT = 5;
    localparam int FAULT_COUNT = 6;

    // reset values
    localparam logic [FAULT_COUNT-1:0] FAULT_LOG_RESET = 6'h00;
    // request pin idles high, all other pins idle low
    localparam logic [7:0] SYNC_RESET = 8'h80;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACTIVE,
        ST_DEACT_RST,
        ST_DEACT_IO
    } cdfs_state_type;
endpackage

`timescale 1ns/1ps
module cdfs_timer #(
    parameter int W = 21
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic start,
    input wire logic [W-1:0] loadValue,
    output logic expired
);
    logic [W-1:0] count;

    // down counter; a fresh start restarts the interval and masks a pending expiry
    always_ff @(posedge clock) begin
        if (srst) begin
            count <= '0;
            expired <= 1'b0;
        end else begin
            expired <= (count == W'(1)) && !start;
            if (start) begin
                count <= loadValue;
            end else if (count != '0) begin
                count <= count - W'(1);
            end
        end
    end
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    import cdfs_pkg::*;
    localparam int DBC = 50;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic wantSession = 1'b0;
    logic cardDetect = 1'b0;
    logic [5:1] faults = 5'h0;
    logic hreadyout, hresp, eventN, sessionRequestN, resetIn;
    logic cardResetOut, cardClockOut, cardDataLowOut, cardAuxALowOut, cardAuxBLowOut;
    logic cardSupplyOut;
    logic [31:0] hrdata, rd;
    int badCount = 0;
    int samplesChecked = 0;
    int n;
    initial forever #2.5 clock = ~clock;
    cdfs_sequencer #(.DebounceCycles(DBC)) dut (.clock(clock), .srst(srst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sessionRequestN(sessionRequestN), .resetIn(resetIn), .eventN(eventN),
        .cardDetect(cardDetect), .hostSupplyLow(faults[1]), .cardSupplyFault(faults[2]),
        .cardSupplyRangeFault(faults[3]), .regulatorInputLow(faults[4]), .overTemp(faults[5]),
        .cardResetOut(cardResetOut), .cardClockOut(cardClockOut),
        .cardDataLowOut(cardDataLowOut), .cardAuxALowOut(cardAuxALowOut),
        .cardAuxBLowOut(cardAuxBLowOut), .cardSupplyOut(cardSupplyOut));
    cdfs_host_model host (.clock(clock), .srst(srst), .wantSession(wantSession),
        .eventN(eventN), .sessionRequestN(sessionRequestN), .resetIn(resetIn));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            badCount++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samplesChecked, badCount);
        if (badCount == 0 && samplesChecked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
    endtask
    // single word transfer; waits on ready in both phases
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask
    function automatic logic pick(input int sel);
        return sel == 0 ? cardSupplyOut : (sel == 1 ? cardResetOut : cardClockOut);
    endfunction
    // bounded wait; a miss shows up in the comparison that follows
    task automatic waitOn(input int sel, input logic v, output int cnt);
        cnt = 0;
        while (pick(sel) !== v && cnt < 4000) begin
            @(posedge clock);
            cnt++;
        end
    endtask
    initial begin
        repeat (80000) @(posedge clock);
        badCount++;
        final_report;
    end
    initial begin
        void'($urandom(32'ha3e34026));
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        cyc(4);
        ahb(1'b0, REG_STATUS, 32'h0, rd);
        check(rd, 32'h0);
        ahb(1'b0, 8'h0c, 32'h0, rd);
        check(rd, 32'h0);
        check(32'(eventN), 32'h0);
        ahb(1'b0, REG_FAULT_LOG, 32'h0, rd);
        check(rd, 32'h1);
        // insertion must wait out the debounce
        cardDetect <= 1'b1;
        cyc(DBC - 5);
        check(32'(eventN), 32'h0);
        cyc(15);
        check(32'(eventN), 32'h1);
        faults[1] <= 1'b1;
        cyc(5);
        check(32'(eventN), 32'h0);
        faults[1] <= 1'b0;
        cyc(5);
        check(32'(eventN), 32'h1);
        // normal close by the host
        wantSession <= 1'b1;
        waitOn(0, 1'b1, n);
        check(32'(cardClockOut), 32'h1);
        cyc($urandom_range(10, 60));
        wantSession <= 1'b0;
        waitOn(1, 1'b0, n);
        waitOn(2, 1'b0, n);
        check(32'(n inside {[2398:2403]}), 32'h1);
        check({cardDataLowOut, cardAuxALowOut, cardAuxBLowOut, cardSupplyOut}, 32'hf);
        cyc(1);
        check(32'(cardSupplyOut), 32'h0);
        // every fault kind in turn, at a random point of the session
        for (int i = 0; i < 6; i++) begin
            wantSession <= 1'b1;
            waitOn(0, 1'b1, n);
            check(32'(cardSupplyOut), 32'h1);
            cyc($urandom_range(5, 200));
            if (i == 0) begin
                cardDetect <= 1'b0;
            end else begin
                faults[i] <= 1'b1;
            end
            cyc(5);
            check(32'(eventN), 32'h0);
            waitOn(0, 1'b0, n);
            check(32'(cardClockOut), 32'h0);
            wantSession <= 1'b0;
            faults <= 5'h0;
            cardDetect <= 1'b1;
            cyc(DBC + 20);
            check(32'(eventN), 32'h1);
        end
        ahb(1'b0, REG_FAULT_LOG, 32'h0, rd);
        check(rd, 32'h3f);
        ahb(1'b1, REG_FAULT_LOG, 32'h3f, rd);
        ahb(1'b0, REG_FAULT_LOG, 32'h0, rd);
        check(rd, 32'h0);
        final_report;
    end
endmodule
